/* File: core/msa_pkg.sv */
package msa_pkg;
    // ****************************************
    // Program space
    // ****************************************
    localparam int PROG_ADDR_W = 24;
    localparam int PROG_WORD_W = 24;
    localparam logic [23:0] PROG_RESET_ADDR = 24'h000000;
    localparam logic [23:0] PROG_RESET_TARGET = 24'h000002;
    localparam logic [23:0] PROG_IVT_LO = 24'h000004;
    localparam logic [23:0] PROG_IVT_LO_END = 24'h0000ff;
    localparam logic [23:0] PROG_IVT_HI = 24'h000100;
    localparam logic [23:0] PROG_IVT_HI_END = 24'h0001ff;
    localparam logic [23:0] PROG_VECTOR_END = 24'h000200;
    localparam logic [23:0] PROG_USER_MAX = 24'h7fffff;
    localparam logic [23:0] PROG_STEP = 24'h000002;

    // ****************************************
    // Data space
    // ****************************************
    localparam int DATA_ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int WINDOW_BIT = 15;
    localparam logic [15:0] DATA_IMPL_END = 16'h77ff;
    localparam logic [15:0] SFR_END = 16'h07ff;
    localparam logic [15:0] NEAR_END = 16'h1fff;
    localparam int NEAR_FIELD_W = 13;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam int RAM_WORDS = 15360;
    localparam int RAM_IDX_W = 14;

    // ****************************************
    // Extend operations on a loaded byte
    // ****************************************
    typedef enum logic [1:0] {
        EXT_NONE = 2'h0,
        EXT_SIGN = 2'h1,
        EXT_ZERO = 2'h2
    } msa_ext_type;
endpackage

/* File: core/msa_memory_space.sv */
`timescale 1ns/1ps
module msa_memory_space
    import msa_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Program fetch
    input wire logic fetchStep,
    input wire logic fetchBackward,
    input wire logic fetchLoad,
    input wire logic [23:0] fetchTarget,
    input wire logic tableAccess,
    output logic [23:0] programCounter,
    output logic fetchInVectorArea,
    output logic fetchInIvtLow,
    output logic fetchInIvtHigh,
    output logic fetchIllegal,
    // Read address generator
    input wire logic rdValid,
    input wire logic rdByte,
    input wire logic rdPostInc,
    input wire logic [1:0] rdMode,
    input wire logic [15:0] rdPointer,
    input wire logic [15:0] rdDirect,
    input wire logic [12:0] rdNear,
    input wire logic [15:0] rdDestOld,
    input wire logic [1:0] rdExtend,
    output logic [15:0] rdData,
    output logic [15:0] rdDestNew,
    output logic [15:0] rdPointerNext,
    output logic rdToWindow,
    // Window return data
    input wire logic [15:0] windowData,
    // Special register space
    input wire logic [15:0] sfrData,
    input wire logic sfrHit,
    output logic sfrReadSel,
    // Write address generator
    input wire logic wrValid,
    input wire logic wrByte,
    input wire logic wrPostInc,
    input wire logic [1:0] wrMode,
    input wire logic [15:0] wrPointer,
    input wire logic [15:0] wrDirect,
    input wire logic [12:0] wrNear,
    input wire logic [15:0] wrData,
    output logic [15:0] wrPointerNext,
    output logic [1:0] wrLaneStrobe,
    output logic [15:0] wrAddress,
    // Exception logic
    input wire logic trapAck,
    output logic addressTrap
);
    // ****************************************
    // Program counter
    // ****************************************
    logic [23:0] pc_q;
    logic [23:0] pc_d;
    wire [23:0] pcStepped = fetchBackward ? pc_q - PROG_STEP : pc_q + PROG_STEP;
    // Lower and upper word pair one location, so targets land on the even half
    wire [23:0] targetAligned = {fetchTarget[23:1], 1'b0};

    always_comb begin
        pc_d = pc_q;
        if (fetchLoad) begin
            pc_d = targetAligned;
        end else if (fetchStep) begin
            pc_d = pcStepped;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            pc_q <= PROG_RESET_ADDR;
        end else begin
            pc_q <= pc_d;
        end
    end

    assign programCounter = pc_q;
    assign fetchInVectorArea = pc_q < PROG_VECTOR_END;
    assign fetchInIvtLow = pc_q >= PROG_IVT_LO && pc_q <= PROG_IVT_LO_END;
    assign fetchInIvtHigh = pc_q >= PROG_IVT_HI && pc_q <= PROG_IVT_HI_END;
    assign fetchIllegal = !tableAccess && pc_q > PROG_USER_MAX;

    // ****************************************
    // Address generation
    // ****************************************
    // Mode 0 pointer, 1 direct 16-bit, 2 near 13-bit
    wire [15:0] nearRd = {3'h0, rdNear};
    wire [15:0] nearWr = {3'h0, wrNear};
    wire [15:0] rdAddr = rdMode == 2'h1 ? rdDirect : (rdMode == 2'h2 ? nearRd : rdPointer);
    wire [15:0] wrAddr = wrMode == 2'h1 ? wrDirect : (wrMode == 2'h2 ? nearWr : wrPointer);
    wire [15:0] rdStep = rdByte ? STEP_BYTE : STEP_WORD;
    wire [15:0] wrStep = wrByte ? STEP_BYTE : STEP_WORD;
    assign rdPointerNext = rdPostInc ? rdPointer + rdStep : rdPointer;
    assign wrPointerNext = wrPostInc ? wrPointer + wrStep : wrPointer;

    // ****************************************
    // Decode
    // ****************************************
    wire rdWin = rdAddr[WINDOW_BIT];
    wire rdSfr = !rdWin && rdAddr <= SFR_END;
    wire rdRam = !rdWin && rdAddr > SFR_END && rdAddr <= DATA_IMPL_END;
    wire wrWin = wrAddr[WINDOW_BIT];
    wire wrRam = !wrWin && wrAddr > SFR_END && wrAddr <= DATA_IMPL_END;
    wire rdMisaligned = rdValid && !rdByte && rdAddr[0];
    wire wrMisaligned = wrValid && !wrByte && wrAddr[0];
    assign rdToWindow = rdValid && rdWin;
    assign sfrReadSel = rdValid && rdSfr;

    // ****************************************
    // Storage, two byte lanes
    // ****************************************
    logic [7:0] lowLane [RAM_WORDS];
    logic [7:0] highLane [RAM_WORDS];
    wire [15:0] rdRamOff = rdAddr - SFR_END - 16'h0001;
    wire [15:0] wrRamOff = wrAddr - SFR_END - 16'h0001;
    wire [RAM_IDX_W-1:0] rdIdx = rdRamOff[RAM_IDX_W:1];
    wire [RAM_IDX_W-1:0] wrIdx = wrRamOff[RAM_IDX_W:1];
    wire wrGo = wrValid && !wrMisaligned;
    wire wrLowLane = wrGo && (!wrByte || !wrAddr[0]);
    wire wrHighLane = wrGo && (!wrByte || wrAddr[0]);
    wire [7:0] wrHighByte = wrByte ? wrData[7:0] : wrData[15:8];
    assign wrLaneStrobe = {wrHighLane, wrLowLane};
    assign wrAddress = wrAddr;

    always_ff @(posedge clock) begin
        if (wrLowLane && wrRam) begin
            lowLane[wrIdx] <= wrData[7:0];
        end
        if (wrHighLane && wrRam) begin
            highLane[wrIdx] <= wrHighByte;
        end
    end

    // ****************************************
    // Read return
    // ****************************************
    wire [15:0] ramWord = {highLane[rdIdx], lowLane[rdIdx]};
    wire [15:0] sfrWord = sfrHit ? sfrData : 16'h0000;
    wire [15:0] srcWord = rdWin ? windowData : (rdSfr ? sfrWord : (rdRam ? ramWord : 16'h0000));
    wire [7:0] selByte = rdAddr[0] ? srcWord[15:8] : srcWord[7:0];
    wire [15:0] rdValue = rdByte ? {8'h00, selByte} : srcWord;
    wire [15:0] signExt = {{8{selByte[7]}}, selByte};
    wire [15:0] zeroExt = {8'h00, selByte};
    wire [15:0] byteLoad = {rdDestOld[15:8], selByte};
    wire [15:0] destByte = rdExtend == EXT_SIGN ? signExt : (rdExtend == EXT_ZERO ? zeroExt : byteLoad);
    wire [15:0] destValue = rdByte ? destByte : srcWord;
    logic [15:0] rdData_q;
    logic [15:0] rdDest_q;

    always_ff @(posedge clock) begin
        if (reset) begin
            rdData_q <= 16'h0000;
            rdDest_q <= 16'h0000;
        end else if (rdValid) begin
            rdData_q <= rdValue;
            rdDest_q <= destValue;
        end
    end

    assign rdData = rdData_q;
    assign rdDestNew = rdDest_q;

    // ****************************************
    // Address error trap
    // ****************************************
    // New fault wins over a same-cycle acknowledge
    logic trap_q;
    logic trap_d;
    assign trap_d = (rdMisaligned || wrMisaligned) ? 1'b1 : (trapAck ? 1'b0 : trap_q);

    always_ff @(posedge clock) begin
        if (reset) begin
            trap_q <= 1'b0;
        end else begin
            trap_q <= trap_d;
        end
    end

    assign addressTrap = trap_q;

    // ****************************************
    // Checks
    // ****************************************
    AST_RESET_PC: assert property (@(posedge clock) reset |=> pc_q == PROG_RESET_ADDR)
        else $error("pc not at reset address");
    AST_PC_STEP: assert property (@(posedge clock) disable iff (reset)
        fetchStep && !fetchLoad && !fetchBackward |=> pc_q == $past(pc_q) + PROG_STEP)
        else $error("pc did not step by two");
    AST_PC_EVEN: assert property (@(posedge clock) disable iff (reset) !pc_q[0])
        else $error("pc odd");
    AST_TRAP_SET: assert property (@(posedge clock) disable iff (reset)
        rdMisaligned |=> addressTrap)
        else $error("trap not raised");
    AST_TRAP_HOLD: assert property (@(posedge clock) disable iff (reset)
        addressTrap && !trapAck |=> addressTrap)
        else $error("trap dropped early");
    AST_WR_SUPPRESS: assert property (@(posedge clock) disable iff (reset)
        wrMisaligned |-> wrLaneStrobe == 2'h0)
        else $error("misaligned write not suppressed");
    AST_BYTE_LANE: assert property (@(posedge clock) disable iff (reset)
        wrValid && wrByte |-> wrLaneStrobe == (wrAddr[0] ? 2'h2 : 2'h1))
        else $error("wrong byte lane");
    AST_UNIMPL_ZERO: assert property (@(posedge clock) disable iff (reset)
        rdValid && !rdWin && !rdSfr && !rdRam |=> rdData == 16'h0000)
        else $error("unimplemented read nonzero");
    AST_BYTE_HIGH_KEEP: assert property (@(posedge clock) disable iff (reset)
        rdValid && rdByte && rdExtend == EXT_NONE |=> rdDestNew[15:8] == $past(rdDestOld[15:8]))
        else $error("byte load touched high byte");
    AST_POST_STEP: assert property (@(posedge clock) disable iff (reset)
        rdPostInc |-> rdPointerNext - rdPointer == (rdByte ? STEP_BYTE : STEP_WORD))
        else $error("post modify step wrong");
    COV_TRAP_ACK: cover property (@(posedge clock) addressTrap ##1 trapAck ##1 !addressTrap);
    COV_BYTE_WRITE: cover property (@(posedge clock) wrValid && wrByte && wrAddr[0]);
    COV_WINDOW_READ: cover property (@(posedge clock) rdValid && rdWin);
    COV_SFR_READ: cover property (@(posedge clock) rdValid && rdSfr && !sfrHit);
    COV_MISALIGNED_READ: cover property (@(posedge clock) rdMisaligned ##1 addressTrap);

    // ****************************************
    // Program space checks
    // ****************************************
    AST_VECTOR_AREA: assert property (@(posedge clock) disable iff (reset)
        fetchInIvtLow || fetchInIvtHigh |-> fetchInVectorArea)
        else $error("vector table outside vector area");
    AST_IVT_DISJOINT: assert property (@(posedge clock) disable iff (reset)
        !(fetchInIvtLow && fetchInIvtHigh))
        else $error("both vector tables hit");
    AST_RESET_SLOT: assert property (@(posedge clock) disable iff (reset)
        pc_q < PROG_IVT_LO |-> !fetchInIvtLow && !fetchInIvtHigh)
        else $error("reset slot decoded as vector table");
    AST_PC_BACK: assert property (@(posedge clock) disable iff (reset)
        fetchStep && !fetchLoad && fetchBackward |=> pc_q == $past(pc_q) - PROG_STEP)
        else $error("pc did not step back by two");
    AST_PC_LOAD: assert property (@(posedge clock) disable iff (reset)
        fetchLoad |=> pc_q == {$past(fetchTarget[23:1]), 1'b0})
        else $error("pc load wrong");
    AST_PC_HOLD: assert property (@(posedge clock) disable iff (reset)
        !fetchLoad && !fetchStep |=> $stable(pc_q))
        else $error("pc moved without request");
    AST_ILLEGAL: assert property (@(posedge clock) disable iff (reset)
        fetchIllegal |-> !tableAccess && pc_q[23])
        else $error("illegal flag without upper half");
    AST_TABLE_OK: assert property (@(posedge clock) disable iff (reset)
        tableAccess |-> !fetchIllegal)
        else $error("table access flagged illegal");

    // ****************************************
    // Data space checks
    // ****************************************
    AST_EA_LOWHALF: assert property (@(posedge clock) disable iff (reset)
        rdValid && !rdAddr[15] |-> !rdToWindow)
        else $error("lower half routed to window");
    AST_WINDOW_ROUTE: assert property (@(posedge clock) disable iff (reset)
        rdValid && rdAddr[15] |-> rdToWindow && !sfrReadSel)
        else $error("upper half not routed to window");
    AST_WINDOW_DATA: assert property (@(posedge clock) disable iff (reset)
        rdValid && rdWin && !rdByte |=> rdData == $past(windowData))
        else $error("window data not returned");
    AST_RAM_ZERO_TOP: assert property (@(posedge clock) disable iff (reset)
        rdValid && !rdWin && rdAddr > DATA_IMPL_END |=> rdData == 16'h0000)
        else $error("read above memory nonzero");
    AST_SFR_SEL: assert property (@(posedge clock) disable iff (reset)
        rdValid && rdAddr <= SFR_END |-> sfrReadSel)
        else $error("special register area not selected");
    AST_SFR_DATA: assert property (@(posedge clock) disable iff (reset)
        rdValid && rdSfr && sfrHit && !rdByte |=> rdData == $past(sfrData))
        else $error("special register data lost");
    AST_SFR_UNUSED: assert property (@(posedge clock) disable iff (reset)
        rdValid && rdSfr && !sfrHit |=> rdData == 16'h0000)
        else $error("unused special register nonzero");
    AST_BYTE_HIGH_ZERO: assert property (@(posedge clock) disable iff (reset)
        rdValid && rdByte |=> rdData[15:8] == 8'h00)
        else $error("byte read high lane not zero");
    AST_BYTE_ODD_LANE: assert property (@(posedge clock) disable iff (reset)
        rdValid && rdByte && rdAddr[0] |=> rdData[7:0] == $past(srcWord[15:8]))
        else $error("odd byte not from high lane");
    AST_BYTE_EVEN_LANE: assert property (@(posedge clock) disable iff (reset)
        rdValid && rdByte && !rdAddr[0] |=> rdData[7:0] == $past(srcWord[7:0]))
        else $error("even byte not from low lane");
    AST_SIGN_EXT: assert property (@(posedge clock) disable iff (reset)
        rdValid && rdByte && rdExtend == EXT_SIGN |=> rdDestNew == {{8{rdData[7]}}, rdData[7:0]})
        else $error("sign extend wrong");
    AST_ZERO_EXT: assert property (@(posedge clock) disable iff (reset)
        rdValid && rdByte && rdExtend == EXT_ZERO |=> rdDestNew == rdData)
        else $error("zero extend wrong");
    AST_WORD_STROBE: assert property (@(posedge clock) disable iff (reset)
        wrValid && !wrByte && !wrAddr[0] |-> wrLaneStrobe == 2'h3)
        else $error("word write missing a lane");
    AST_NO_WRITE_IDLE: assert property (@(posedge clock) disable iff (reset)
        !wrValid |-> wrLaneStrobe == 2'h0)
        else $error("strobe without write");
    AST_WR_POINTER: assert property (@(posedge clock) disable iff (reset)
        wrMode == 2'h0 |-> wrAddress == wrPointer)
        else $error("write pointer address wrong");
    AST_WR_DIRECT: assert property (@(posedge clock) disable iff (reset)
        wrMode == 2'h1 |-> wrAddress == wrDirect)
        else $error("write direct address wrong");
    AST_WR_NEAR: assert property (@(posedge clock) disable iff (reset)
        wrMode == 2'h2 |-> wrAddress == {3'h0, wrNear})
        else $error("write near address wrong");
    AST_RD_NEAR: assert property (@(posedge clock) disable iff (reset)
        rdValid && rdMode == 2'h2 |-> !rdToWindow)
        else $error("near read reached window");
    AST_WR_POST_STEP: assert property (@(posedge clock) disable iff (reset)
        wrPostInc |-> wrPointerNext - wrPointer == (wrByte ? STEP_BYTE : STEP_WORD))
        else $error("write post modify step wrong");
    AST_NO_POST: assert property (@(posedge clock) disable iff (reset)
        !rdPostInc |-> rdPointerNext == rdPointer)
        else $error("pointer moved without post modify");

    // ****************************************
    // Trap checks
    // ****************************************
    AST_WRMIS_TRAP: assert property (@(posedge clock) disable iff (reset)
        wrMisaligned |=> addressTrap)
        else $error("misaligned write did not trap");
    AST_READ_COMPLETES: assert property (@(posedge clock) disable iff (reset)
        rdMisaligned |=> rdData == $past(srcWord))
        else $error("misaligned read not completed");
    AST_TRAP_CLEAR: assert property (@(posedge clock) disable iff (reset)
        addressTrap && trapAck && !rdMisaligned && !wrMisaligned |=> !addressTrap)
        else $error("trap not cleared by acknowledge");
    AST_TRAP_CAUSE: assert property (@(posedge clock) disable iff (reset)
        $rose(addressTrap) |-> $past(rdMisaligned || wrMisaligned))
        else $error("trap without fault");
endmodule

/* File: verification/msa_core_model.sv */
`timescale 1ns/1ps
// ****************************************
// Register and window responders beside the core
// ****************************************
module msa_core_model (
    // Select from the block
    input wire logic sfrReadSel,
    input wire logic respond,
    // Answers
    output logic [15:0] sfrData,
    output logic sfrHit,
    output logic [15:0] windowData
);
    // Unselected bus shows garbage, never a helpful last value
    assign sfrHit = sfrReadSel & respond;
    assign sfrData = sfrHit ? 16'h5a5a : 16'ha5a5;
    assign windowData = 16'h3c3c;
endmodule

/* File: verification/test_msa_memory_space.sv */
`timescale 1ns/1ps
module test_msa_memory_space;
    import msa_pkg::*;
    typedef struct {logic w; logic b; logic [15:0] a; logic [15:0] d; logic [15:0] e;} msa_row_type;
    logic clock = 0, reset = 1, fetchStep = 0, fetchBackward = 0, fetchLoad = 0, tableAccess = 0, respond = 0;
    logic rdValid = 0, rdByte = 0, rdPostInc = 1, wrValid = 0, wrByte = 0, wrPostInc = 1, trapAck = 0;
    logic [1:0] rdMode = 0, rdExtend = 0, wrMode = 0, wrLaneStrobe;
    logic [23:0] fetchTarget = 0, programCounter;
    logic [15:0] rdPointer = 0, rdDirect = 0, rdDestOld = 0, wrPointer = 0, wrDirect = 0, wrData = 0;
    logic [12:0] rdNear = 0, wrNear = 0;
    logic [15:0] rdData, rdDestNew, rdPointerNext, windowData, sfrData, wrPointerNext, wrAddress;
    logic fetchInVectorArea, fetchInIvtLow, fetchInIvtHigh, fetchIllegal, rdToWindow, sfrHit, sfrReadSel, addressTrap;
    int miscompares = 0, samplesChecked = 0;
    msa_row_type rows [10] = '{'{1, 0, 16'h0800, 16'h1234, 16'h3}, '{0, 0, 16'h0800, 0, 16'h1234},
        '{1, 1, 16'h0801, 16'h00ab, 16'h2}, '{0, 0, 16'h0800, 0, 16'hab34}, '{0, 1, 16'h0801, 0, 16'h00ab},
        '{0, 1, 16'h0800, 0, 16'h0034}, '{1, 1, 16'h0800, 16'h00cd, 16'h1}, '{0, 0, 16'h0800, 0, 16'habcd},
        '{0, 0, 16'h7800, 0, 16'h0}, '{0, 0, 16'h8000, 0, 16'h3c3c}};
    logic [15:0] extExp [3] = '{16'h12ab, 16'hffab, 16'h00ab};

    always #5 clock = ~clock;

    msa_memory_space DUT (.clock(clock), .reset(reset), .fetchStep(fetchStep), .fetchBackward(fetchBackward),
        .fetchLoad(fetchLoad), .fetchTarget(fetchTarget), .tableAccess(tableAccess), .programCounter(programCounter),
        .fetchInVectorArea(fetchInVectorArea), .fetchInIvtLow(fetchInIvtLow), .fetchInIvtHigh(fetchInIvtHigh),
        .fetchIllegal(fetchIllegal), .rdValid(rdValid), .rdByte(rdByte), .rdPostInc(rdPostInc), .rdMode(rdMode),
        .rdPointer(rdPointer), .rdDirect(rdDirect), .rdNear(rdNear), .rdDestOld(rdDestOld), .rdExtend(rdExtend),
        .rdData(rdData), .rdDestNew(rdDestNew), .rdPointerNext(rdPointerNext), .rdToWindow(rdToWindow),
        .windowData(windowData), .sfrData(sfrData), .sfrHit(sfrHit), .sfrReadSel(sfrReadSel), .wrValid(wrValid),
        .wrByte(wrByte), .wrPostInc(wrPostInc), .wrMode(wrMode), .wrPointer(wrPointer), .wrDirect(wrDirect),
        .wrNear(wrNear), .wrData(wrData), .wrPointerNext(wrPointerNext), .wrLaneStrobe(wrLaneStrobe),
        .wrAddress(wrAddress), .trapAck(trapAck), .addressTrap(addressTrap));

    msa_core_model partner (.sfrReadSel(sfrReadSel), .respond(respond), .sfrData(sfrData), .sfrHit(sfrHit),
        .windowData(windowData));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
        samplesChecked++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    // Unused address sources point at zero-reading places, so a wrong mode shows
    task automatic rd(input logic [1:0] md, input logic bt, input logic [15:0] a, input logic [1:0] ex);
        @(posedge clock);
        {rdMode, rdByte, rdExtend, rdValid} <= {md, bt, ex, 1'b1};
        rdPointer <= (md == 2'h0) ? a : 16'h7900;
        rdDirect <= (md == 2'h1) ? a : 16'h7900;
        rdNear <= (md == 2'h2) ? a[12:0] : 13'h0100;
        #1;
        if (md == 2'h0) chk("rdPointerNext", rdPointerNext, a + (bt ? 16'h1 : 16'h2));
        chk("rdToWindow", rdToWindow, a[15]);
        chk("sfrReadSel", sfrReadSel, !a[15] && a <= 16'h07ff);
        @(posedge clock);
        rdValid <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic bt, input logic [15:0] a, input logic [15:0] d, input logic [1:0] es);
        @(posedge clock);
        {wrByte, wrPointer, wrData, wrValid} <= {bt, a, d, 1'b1};
        #1;
        chk("wrLaneStrobe", wrLaneStrobe, es);
        chk("wrAddress", wrAddress, a);
        chk("wrPointerNext", wrPointerNext, a + (bt ? 16'h1 : 16'h2));
        @(posedge clock);
        wrValid <= 1'b0;
        #1;
    endtask

    task automatic fe(input logic [2:0] sbl, input logic [23:0] t, input logic tb, input logic [23:0] ep,
        input logic [3:0] ef);
        @(posedge clock);
        {fetchStep, fetchBackward, fetchLoad, fetchTarget, tableAccess} <= {sbl, t, tb};
        @(posedge clock);
        {fetchStep, fetchLoad} <= 2'b00;
        #1;
        chk("programCounter", programCounter, ep);
        chk("fetchFlags", {fetchInVectorArea, fetchInIvtLow, fetchInIvtHigh, fetchIllegal}, ef);
    endtask

    task automatic ack();
        @(posedge clock);
        trapAck <= 1'b1;
        @(posedge clock);
        trapAck <= 1'b0;
        #1;
        chk("addressTrap", addressTrap, 0);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge clock);
        #1;
        chk("programCounter", programCounter, PROG_RESET_ADDR);
        chk("rdData", rdData, 0);
        chk("addressTrap", addressTrap, 0);
        @(posedge clock);
        reset <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].b, rows[i].a, rows[i].d, rows[i].e[1:0]);
            else begin
                rd(2'h0, rows[i].b, rows[i].a, EXT_NONE);
                chk("rdData", rdData, rows[i].e);
            end
        end
        rd(2'h0, 1'b0, 16'h0100, EXT_NONE);
        chk("rdData", rdData, 0);
        respond <= 1'b1;
        rd(2'h0, 1'b0, 16'h0100, EXT_NONE);
        chk("sfrRead", rdData, 16'h5a5a);
        respond <= 1'b0;
        rd(2'h1, 1'b0, 16'h0800, EXT_NONE);
        chk("rdData", rdData, 16'habcd);
        rd(2'h2, 1'b0, 16'h0800, EXT_NONE);
        chk("rdData", rdData, 16'habcd);
        rdDestOld <= 16'h1200;
        for (int k = 0; k < 3; k++) begin
            rd(2'h0, 1'b1, 16'h0801, 2'(k));
            chk("rdDestNew", rdDestNew, extExp[k]);
        end
        // Misaligned write: trap held, memory untouched
        wr(1'b0, 16'h0801, 16'hffff, 2'h0);
        chk("addressTrap", addressTrap, 1);
        repeat (3) @(posedge clock);
        #1;
        chk("addressTrap", addressTrap, 1);
        ack();
        rd(2'h0, 1'b0, 16'h0800, EXT_NONE);
        chk("rdData", rdData, 16'habcd);
        rd(2'h0, 1'b0, 16'h0801, EXT_NONE);
        chk("addressTrap", addressTrap, 1);
        ack();
        fe(3'b100, 0, 0, 24'h000002, 4'b1000);
        fe(3'b110, 0, 0, 24'h000000, 4'b1000);
        fe(3'b001, 24'h000103, 0, 24'h000102, 4'b1010);
        fe(3'b001, 24'h000010, 0, 24'h000010, 4'b1100);
        fe(3'b001, 24'h800000, 0, 24'h800000, 4'b0001);
        fe(3'b001, 24'h800000, 1, 24'h800000, 4'b0000);
        fe(3'b001, 24'h000400, 0, 24'h000400, 4'b0000);
        print_verdict();
    end

    // Whole run is under a hundred cycles
    initial begin
        #20000;
        miscompares++;
        print_verdict();
    end
endmodule
